/* verilog/dlvds_pkg.sv */
/*
 * constants shared by the display link serializer and its buffer.
 * assumes a 100 mhz system clock that stands in for the multiplied bit clock.
 */
package dlvds_pkg;
    // ----------------------------------------------------------------
    // word and channel layout
    // ----------------------------------------------------------------
    localparam int COLOR_W = 6;                    // bits per colour
    localparam int CTRL_W = 3;                     // line sync, frame sync, pixel valid
    localparam int WORD_W = 3 * COLOR_W + CTRL_W;  // 21 bits per pixel clock
    localparam int CHAN_N = 3;                     // serial data channels
    localparam int SLOT_N = 7;                     // bit slots per pixel clock
    localparam logic [2:0] SLOT_FIRST = 3'h0;
    localparam logic [2:0] SLOT_LAST = 3'h6;
    localparam logic [6:0] CLK_PATTERN = 7'h63;   // forwarded clock, slot 0 is bit 6
    localparam int BUF_DEPTH = 2;                  // entries in the word buffer

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int SYS_CLK_KHZ = 100000;           // 100 mhz system clock
    localparam int STARTUP_MS = 10;                // wait before outputs toggle
    localparam int STARTUP_CYCLES = STARTUP_MS * SYS_CLK_KHZ;

    // ----------------------------------------------------------------
    // reset values and states
    // ----------------------------------------------------------------
    localparam logic [WORD_W-1:0] IDLE_WORD = 21'h000000;
    localparam logic [31:0] CNT_RESET = 32'h00000000;

    typedef enum logic [2:0] {
        DLVDS_ST_PD = 3'b001,                      // powered down, outputs released
        DLVDS_ST_LOCK = 3'b010,                    // multiplier settling
        DLVDS_ST_RUN = 3'b100                      // serializing
    } dlvds_state_t;
endpackage

/* verilog/dlvds_fifo.sv */
/*
 * small word buffer with valid and ready on both sides.
 * assumes a single clock and a synchronous active low reset.
 */
`timescale 1ns/1ps
module dlvds_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 2
) (
    input wire logic sys_clk,               // system clock
    input wire logic rstn,                  // synchronous reset, active low
    input wire logic flush,                 // drop all entries
    input wire logic in_valid,              // word offered
    output logic in_ready,                  // room for a word
    input wire logic [WIDTH-1:0] in_data,   // word in
    output logic out_valid,                 // word available
    input wire logic out_ready,             // consumer takes word
    output logic [WIDTH-1:0] out_data       // head word
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0] count_reg, count_next;
    logic push, pop;

    // ----------------------------------------------------------------
    // pointer and count update
    // ----------------------------------------------------------------
    assign in_ready = (count_reg != CNT_FULL);
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // next pointers, wrap at the last entry
    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (push) begin
            wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
        if (flush) begin
            wr_ptr_next = '0;
            rd_ptr_next = '0;
            count_next = '0;
        end
    end

    // register pointers; storage needs no reset
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end
endmodule // dlvds_fifo

/* verilog/dlvds_serializer.sv */
/*
 * transmit side of a 21 bit display link: pixel capture, clock crossing,
 * buffering, and 7 slot serialization onto three data pairs and a clock pair.
 * assumes sys_clk stands for the multiplied bit clock and that the
 * controller keeps pixel_clock_in running while power_down_n is high.
 */
`timescale 1ns/1ps
module dlvds_serializer import dlvds_pkg::*; #(
    parameter int STARTUP_CNT = STARTUP_CYCLES
) (
    input wire logic sys_clk,                       // bit clock stand-in, 100 mhz
    input wire logic rstn,                          // synchronous reset, active low
    input wire logic pixel_clock_in,                // pixel clock from controller
    input wire logic [COLOR_W-1:0] red,             // red colour bits
    input wire logic [COLOR_W-1:0] green,           // green colour bits
    input wire logic [COLOR_W-1:0] blue,            // blue colour bits
    input wire logic line_sync,                     // line sync
    input wire logic frame_sync,                    // frame sync
    input wire logic pixel_valid,                   // pixel valid
    input wire logic strobe_edge_select,            // strap: high rising, low falling
    input wire logic power_down_n,                  // power down, active low
    output logic [CHAN_N-1:0] serial_data_pair_p,   // data pairs, true side
    output logic [CHAN_N-1:0] serial_data_pair_n,   // data pairs, complement side
    output logic serial_data_oe,                    // data pairs driven
    output logic forwarded_clock_pair_p,            // forwarded clock, true side
    output logic forwarded_clock_pair_n,            // forwarded clock, complement side
    output logic forwarded_clock_oe                 // clock pair driven
);
    // bit of a word sent on one channel in one slot, msb of each septet first
    function automatic logic slot_bit(input logic [WORD_W-1:0] w, input int ch,
                                      input logic [2:0] slot);
        int idx;
        idx = ch * SLOT_N + (SLOT_N - 1) - int'(slot);
        return w[idx];
    endfunction

    // ----------------------------------------------------------------
    // pixel clock domain: reset, strap, capture, request
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] in_word;
    logic [WORD_W-1:0] fall_word_reg;
    logic [WORD_W-1:0] hold_word_reg, hold_word_next;
    logic pix_rst_s1_reg, pix_rst_n_reg, edge_s1_reg, edge_s2_reg;
    logic ack_s1_reg, ack_s2_reg;
    logic pix_req_reg, pix_req_next;
    logic sys_ack_reg, sys_ack_next;

    assign in_word = {pixel_valid, frame_sync, line_sync, blue, green, red};

    // falling edge copy of the inputs
    always_ff @(negedge pixel_clock_in) begin
        fall_word_reg <= in_word;
    end

    // take a word only when the previous one has been acknowledged
    always_comb begin
        hold_word_next = hold_word_reg;
        pix_req_next = pix_req_reg;
        if (pix_req_reg == ack_s2_reg) begin
            hold_word_next = edge_s2_reg ? in_word : fall_word_reg;
            pix_req_next = !pix_req_reg;
        end
    end

    // synchronisers and request state; reset follows rstn and power down
    always_ff @(posedge pixel_clock_in) begin
        pix_rst_s1_reg <= rstn && power_down_n;
        pix_rst_n_reg <= pix_rst_s1_reg;
        edge_s1_reg <= strobe_edge_select;
        edge_s2_reg <= edge_s1_reg;
        ack_s1_reg <= sys_ack_reg;
        ack_s2_reg <= ack_s1_reg;
        if (!pix_rst_n_reg) begin
            hold_word_reg <= IDLE_WORD;
            pix_req_reg <= 1'b0;
        end else begin
            hold_word_reg <= hold_word_next;
            pix_req_reg <= pix_req_next;
        end
    end

    // ----------------------------------------------------------------
    // system clock domain: crossing and buffer
    // ----------------------------------------------------------------
    logic pdn_s1_reg, pdn_s2_reg, req_s1_reg, req_s2_reg;
    logic fifo_in_ready, fifo_out_valid, fifo_pop, new_word;
    logic [WORD_W-1:0] fifo_out_data;
    dlvds_state_t state_reg, state_next;

    assign new_word = (req_s2_reg != sys_ack_reg);

    // acknowledge once buffered, or discard while not running
    always_comb begin
        sys_ack_next = sys_ack_reg;
        if (new_word && (fifo_in_ready || state_reg != DLVDS_ST_RUN)) begin
            sys_ack_next = req_s2_reg;
        end
    end

    // level synchronisers and acknowledge register
    always_ff @(posedge sys_clk) begin
        pdn_s1_reg <= power_down_n;
        pdn_s2_reg <= pdn_s1_reg;
        req_s1_reg <= pix_req_reg;
        req_s2_reg <= req_s1_reg;
        if (!rstn) begin
            sys_ack_reg <= 1'b0;
        end else begin
            sys_ack_reg <= sys_ack_next;
        end
    end

    dlvds_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(BUF_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .flush(state_reg != DLVDS_ST_RUN),
        .in_valid(new_word && state_reg == DLVDS_ST_RUN),
        .in_ready(fifo_in_ready),
        .in_data(hold_word_reg),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ----------------------------------------------------------------
    // power state, startup wait, slot counter, word load
    // ----------------------------------------------------------------
    logic [31:0] lock_cnt_reg, lock_cnt_next;
    logic [2:0] slot_reg, slot_next;
    logic [WORD_W-1:0] cur_word_reg, cur_word_next;
    localparam logic [31:0] LOCK_LAST = 32'(STARTUP_CNT - 1);

    assign fifo_pop = (state_reg == DLVDS_ST_RUN) && (slot_reg == SLOT_LAST);

    // next state, count and slot
    always_comb begin
        state_next = state_reg;
        lock_cnt_next = lock_cnt_reg;
        slot_next = slot_reg;
        cur_word_next = cur_word_reg;
        case (state_reg)
            DLVDS_ST_PD: begin
                lock_cnt_next = CNT_RESET;
                slot_next = SLOT_FIRST;
                cur_word_next = IDLE_WORD;
                if (pdn_s2_reg) begin
                    state_next = DLVDS_ST_LOCK;
                end
            end
            DLVDS_ST_LOCK: begin
                lock_cnt_next = lock_cnt_reg + 32'h00000001;
                if (lock_cnt_reg == LOCK_LAST) begin
                    state_next = DLVDS_ST_RUN;
                end
            end
            DLVDS_ST_RUN: begin
                if (slot_reg == SLOT_LAST) begin
                    slot_next = SLOT_FIRST;
                    cur_word_next = fifo_out_valid ? fifo_out_data : IDLE_WORD;
                end else begin
                    slot_next = slot_reg + 3'h1;
                end
            end
            default: begin
                state_next = DLVDS_ST_PD;
            end
        endcase
        if (!pdn_s2_reg) begin
            state_next = DLVDS_ST_PD;
        end
    end

    // state registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_reg <= DLVDS_ST_PD;
            lock_cnt_reg <= CNT_RESET;
            slot_reg <= SLOT_FIRST;
            cur_word_reg <= IDLE_WORD;
        end else begin
            state_reg <= state_next;
            lock_cnt_reg <= lock_cnt_next;
            slot_reg <= slot_next;
            cur_word_reg <= cur_word_next;
        end
    end

    // ----------------------------------------------------------------
    // output pairs
    // ----------------------------------------------------------------
    logic [CHAN_N-1:0] data_p_reg, data_p_next, data_n_reg, data_n_next;
    logic clk_p_reg, clk_p_next, clk_n_reg, clk_n_next, oe_reg, oe_next;
    // slot bits while running, quiet and released otherwise
    always_comb begin
        oe_next = (state_reg == DLVDS_ST_RUN);
        clk_p_next = 1'b0;
        data_p_next = '0;
        if (oe_next) begin
            clk_p_next = CLK_PATTERN[SLOT_LAST - slot_reg];
            for (int c = 0; c < CHAN_N; c++) begin
                data_p_next[c] = slot_bit(cur_word_reg, c, slot_reg);
            end
        end
        data_n_next = ~data_p_next & {CHAN_N{oe_next}}; // complement side only while driven
        clk_n_next = !clk_p_next && oe_next;
    end
    // output flip-flops, both sides of every pair registered
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            data_p_reg <= '0;
            data_n_reg <= '0;
            clk_p_reg <= 1'b0;
            clk_n_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            data_p_reg <= data_p_next;
            data_n_reg <= data_n_next;
            clk_p_reg <= clk_p_next;
            clk_n_reg <= clk_n_next;
            oe_reg <= oe_next;
        end
    end
    assign serial_data_pair_p = data_p_reg;
    assign serial_data_pair_n = data_n_reg;
    assign serial_data_oe = oe_reg;
    assign forwarded_clock_pair_p = clk_p_reg;
    assign forwarded_clock_pair_n = clk_n_reg;
    assign forwarded_clock_oe = oe_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_pd_releases: assert property (@(posedge sys_clk) disable iff (!rstn)
        !pdn_s2_reg |-> ##2 (!serial_data_oe && !forwarded_clock_oe))
        else $error("outputs still driven after power down");
    a_quiet_when_off: assert property (@(posedge sys_clk) disable iff (!rstn)
        !serial_data_oe |-> (serial_data_pair_p == '0 && !forwarded_clock_pair_p))
        else $error("outputs toggle while released");
    a_startup_wait: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(serial_data_oe) |-> $past(lock_cnt_reg, 2) == LOCK_LAST)
        else $error("outputs enabled before startup wait");
    a_run_slot_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(state_reg == DLVDS_ST_RUN) |-> (slot_reg == SLOT_FIRST
            && cur_word_reg == IDLE_WORD))
        else $error("serialization restarted off slot zero");
    a_slot_wrap: assert property (@(posedge sys_clk) disable iff (!rstn || !pdn_s2_reg)
        (state_reg == DLVDS_ST_RUN && slot_reg == SLOT_LAST && pdn_s2_reg)
            |=> slot_reg == SLOT_FIRST ##6 slot_reg == SLOT_LAST)
        else $error("slot count not seven");
    a_clock_pattern: assert property (@(posedge sys_clk) disable iff (!rstn)
        $past(state_reg == DLVDS_ST_RUN) |->
            forwarded_clock_pair_p == CLK_PATTERN[SLOT_LAST - $past(slot_reg)])
        else $error("forwarded clock pattern wrong");
    a_data_slot: assert property (@(posedge sys_clk) disable iff (!rstn)
        $past(state_reg == DLVDS_ST_RUN) |->
            serial_data_pair_p[2] == slot_bit($past(cur_word_reg), 2, $past(slot_reg)))
        else $error("serial data bit wrong");
    a_diff_pair: assert property (@(posedge sys_clk) disable iff (!rstn)
        serial_data_oe |-> (serial_data_pair_n == ~serial_data_pair_p
            && forwarded_clock_pair_n != forwarded_clock_pair_p))
        else $error("pair sides not complementary");
    a_word_load: assert property (@(posedge sys_clk) disable iff (!rstn)
        (fifo_pop && fifo_out_valid && pdn_s2_reg) |=> cur_word_reg == $past(fifo_out_data))
        else $error("buffered word not loaded");
    a_rise_capture: assert property (@(posedge pixel_clock_in)
        disable iff (!pix_rst_n_reg) (edge_s2_reg && pix_req_reg == ack_s2_reg) |=>
            hold_word_reg == $past(in_word))
        else $error("rising edge sample wrong");
    a_fall_capture: assert property (@(posedge pixel_clock_in)
        disable iff (!pix_rst_n_reg) (!edge_s2_reg && pix_req_reg == ack_s2_reg) |=>
            hold_word_reg == $past(fall_word_reg))
        else $error("falling edge sample wrong");
    c_run: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(serial_data_oe));
    c_word_sent: cover property (@(posedge sys_clk) disable iff (!rstn)
        fifo_pop && fifo_out_valid);
    c_buffer_full: cover property (@(posedge sys_clk) disable iff (!rstn)
        !fifo_in_ready && new_word);
    c_pd_in_run: cover property (@(posedge sys_clk) disable iff (!rstn)
        state_reg == DLVDS_ST_RUN && !pdn_s2_reg);
endmodule // dlvds_serializer

/* tb/dlvds_rx_model.sv */
/*
 * behavioural link receiver for the display link serializer bench.
 * assumes one sys_clk cycle per bit slot and a released pair reads high.
 */
`timescale 1ns/1ps
module dlvds_rx_model import dlvds_pkg::*; (
    input wire logic sys_clk,                       // bit slot clock
    input wire logic [CHAN_N-1:0] serial_data_pair_p, // data pairs, true side
    input wire logic serial_data_oe,                // data pairs driven
    input wire logic forwarded_clock_pair_p,        // forwarded clock, true side
    input wire logic forwarded_clock_oe,            // clock pair driven
    output logic [WORD_W-1:0] receiver_data_out,    // recovered word
    output logic rx_word_strobe,                    // one cycle per new word
    output logic rx_clock_out                       // recovered clock
);
    logic [6:0] chist;
    logic [6:0] dhist [CHAN_N];

    initial begin
        chist = 7'h00;
        receiver_data_out = IDLE_WORD;
        rx_word_strobe = 1'b0;
        rx_clock_out = 1'b0;
        for (int c = 0; c < CHAN_N; c++) dhist[c] = 7'h00;
    end

    // --------------------------------------------------------------
    // slot shifters and word framing
    // --------------------------------------------------------------
    // a released pair is pulled high by the failsafe bias
    always @(posedge sys_clk) begin
        logic ck;
        logic [WORD_W-1:0] w;
        ck = forwarded_clock_oe ? forwarded_clock_pair_p : 1'b1;
        for (int c = 0; c < CHAN_N; c++) begin
            dhist[c] = {dhist[c][5:0], serial_data_oe ? serial_data_pair_p[c] : 1'b1};
            w[c*7 +: 7] = dhist[c];
        end
        chist = {chist[5:0], ck};
        rx_word_strobe <= 1'b0;
        // a floating clock never matches, so the last word is kept
        if (forwarded_clock_oe && chist == CLK_PATTERN) begin
            receiver_data_out <= w;
            rx_word_strobe <= 1'b1;
        end
        rx_clock_out <= forwarded_clock_oe & ck;
    end
endmodule // dlvds_rx_model

/* tb/dlvds_serializer_tb_top.sv */
/*
 * self-checking bench for the display link serializer with a receiver model.
 * assumes the startup wait parameter is shortened to 20 cycles.
 */
`timescale 1ns/1ps
module dlvds_serializer_tb_top import dlvds_pkg::*;;
    localparam int ST_CNT = 20;
    logic sys_clk, rstn, pixel_clock_in, pix_run, line_sync, frame_sync, pixel_valid;
    logic strobe_edge_select, power_down_n, serial_data_oe, forwarded_clock_oe;
    logic [COLOR_W-1:0] red, green, blue, pcnt;
    logic [CHAN_N-1:0] sdp, sdn;
    logic fcp, fcn, rx_strobe, rx_clk;
    logic [WORD_W-1:0] rx_data;
    logic [WORD_W-1:0] rx_q [$];
    int n_mismatch = 0;
    int cmp_count = 0;

    // --------------------------------------------------------------
    // clocks and pixel source
    // --------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // pixel clock only stands still while pix_run is low
    initial begin
        pixel_clock_in = 1'b0;
        #7;
        forever begin
            #24;
            if (pix_run) pixel_clock_in = ~pixel_clock_in;
        end
    end
    // line sync marks which half of the pixel period a value belongs to
    always @(pixel_clock_in) begin
        #1;
        if (pixel_clock_in) pcnt = pcnt + 6'h01;
        red = pcnt;
        green = ~pcnt;
        blue = pcnt ^ 6'h2A;
        frame_sync = pcnt[0];
        pixel_valid = 1'b1;
        line_sync = ~pixel_clock_in;
    end
    always @(posedge sys_clk) if (rx_strobe && rx_data !== IDLE_WORD) rx_q.push_back(rx_data);

    dlvds_serializer #(.STARTUP_CNT(ST_CNT)) u_dlvds_serializer (
        .sys_clk(sys_clk), .rstn(rstn), .pixel_clock_in(pixel_clock_in),
        .red(red), .green(green), .blue(blue), .line_sync(line_sync),
        .frame_sync(frame_sync), .pixel_valid(pixel_valid),
        .strobe_edge_select(strobe_edge_select), .power_down_n(power_down_n),
        .serial_data_pair_p(sdp), .serial_data_pair_n(sdn), .serial_data_oe(serial_data_oe),
        .forwarded_clock_pair_p(fcp), .forwarded_clock_pair_n(fcn),
        .forwarded_clock_oe(forwarded_clock_oe));
    dlvds_rx_model u_dlvds_rx_model (
        .sys_clk(sys_clk), .serial_data_pair_p(sdp), .serial_data_oe(serial_data_oe),
        .forwarded_clock_pair_p(fcp), .forwarded_clock_oe(forwarded_clock_oe),
        .receiver_data_out(rx_data), .rx_word_strobe(rx_strobe), .rx_clock_out(rx_clk));

    // --------------------------------------------------------------
    // checking and closing
    // --------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    // enable, measure the wait, then check the first seven slots
    task automatic t_startup();
        int n;
        n = 0;
        power_down_n = 1'b1;
        while (forwarded_clock_oe !== 1'b1 && n < ST_CNT + 20) begin
            check({31'h0, serial_data_oe}, 32'h0);
            tick();
            n++;
        end
        check({31'h0, n >= ST_CNT && n <= ST_CNT + 6}, 32'h1);
        for (int i = 0; i < SLOT_N; i++) begin
            check({31'h0, fcp}, {31'h0, CLK_PATTERN[6-i]});
            check({29'h0, sdp}, 32'h0);
            check({28'h0, serial_data_oe, sdn}, {28'h0, 1'b1, ~sdp});
            check({31'h0, fcn}, {31'h0, ~fcp});
            tick();
        end
        $display("test startup done");
    endtask
    // stream pixels and judge every non-idle word that reaches the receiver
    task automatic t_stream(input logic sel);
        int prev;
        logic [WORD_W-1:0] w;
        prev = -1;
        rx_q.delete();
        repeat (200) tick();
        check({31'h0, rx_q.size() >= 5}, 32'h1);
        while (rx_q.size() > 0) begin
            w = rx_q.pop_front();
            check({26'h0, w[11:6]}, {26'h0, ~w[5:0]});
            check({26'h0, w[17:12]}, {26'h0, w[5:0] ^ 6'h2A});
            check({30'h0, w[20:19]}, {30'h0, 1'b1, w[0]});
            check({31'h0, w[18]}, {31'h0, sel});
            check({31'h0, int'(w[5:0]) > prev}, 32'h1);
            prev = int'(w[5:0]);
        end
        $display("test stream sel=%0d done", sel);
    endtask
    // power down mid-stream, then stop and restart the pixel clock
    task automatic t_powerdown();
        int n;
        logic [WORD_W-1:0] held;
        n = 0;
        power_down_n = 1'b0;
        while ((serial_data_oe | forwarded_clock_oe) !== 1'b0 && n < 10) begin
            tick();
            n++;
        end
        check({31'h0, n <= 4}, 32'h1);
        check({24'h0, sdp, sdn, fcp, fcn}, 32'h0);
        held = rx_data;
        repeat (20) tick();
        check({11'h0, rx_data}, {11'h0, held});
        check({31'h0, rx_clk}, 32'h0);
        pix_run = 1'b0;
        repeat (100) tick();
        pcnt = 6'h00;
        pix_run = 1'b1;
        repeat (20) tick();
        $display("test powerdown done");
    endtask

    initial begin
        rstn = 1'b0;
        pix_run = 1'b1;
        pcnt = 6'h00;
        {red, green, blue, line_sync, frame_sync, pixel_valid} = IDLE_WORD;
        strobe_edge_select = 1'b1;
        power_down_n = 1'b0;
        repeat (4) tick();
        rstn = 1'b1;
        repeat (4) tick();
        t_startup();
        t_stream(1'b1);
        t_powerdown();
        strobe_edge_select = 1'b0;
        repeat (4) tick();
        t_startup();
        t_stream(1'b0);
        tally_and_finish();
    end
    // watchdog well beyond the expected run of about 620 cycles
    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule // dlvds_serializer_tb_top
